// [common/adc_seq_pkg.sv]
// Purpose: shared constants and carrier types for the converter sequencer
// Assumes: 125 MHz core clock; converter clock made by an enable divider
// Notes:   times are kept in their own unit, counts derived from them
package adc_seq_pkg;

    localparam int CORE_CLK_MHZ        = 125;
    localparam int CHANNEL_COUNT       = 16;
    localparam int CHANNEL_W           = 4;
    localparam int RESULT_W            = 12;
    localparam int ACQ_W               = 4;
    localparam int PIPE_STAGES         = 4;
    // converter clock divider: 125 MHz / 5 = 25 MHz
    localparam int CONV_CLK_DIV        = 5;
    // reference settle (ms) and core power settle (us)
    localparam int REF_SETTLE_MS       = 5;
    localparam int CORE_SETTLE_MIN_US  = 20;
    localparam int REF_SETTLE_CYCLES   = REF_SETTLE_MS * 1000 * CORE_CLK_MHZ;
    localparam int CORE_SETTLE_CYCLES  = CORE_SETTLE_MIN_US * CORE_CLK_MHZ;
    // trigger to sample start: 2.5 converter periods, in half periods
    localparam int TRIG_DELAY_HALVES   = 5;
    // end of sample/hold to first result, converter periods
    localparam int FIRST_RESULT_CLKS   = 4;
    // successive result spacing is this plus the acquisition field
    localparam int NEXT_RESULT_BASE    = 2;
    // core cycles from result update to flag
    localparam int FLAG_DELAY_CYCLES   = 3;
    // control register 3 bit positions
    localparam int CTRL3_BGREF1_BIT    = 7;
    localparam int CTRL3_BGREF0_BIT    = 6;
    localparam int CTRL3_CORE_PWR_BIT  = 5;
    // control register 1 acquisition field
    localparam int CTRL1_ACQ_LSB       = 8;
    localparam int CTRL1_ACQ_MSB       = 11;

    typedef struct packed {
        logic                 valid;
        logic [CHANNEL_W-1:0] channel;
        logic [RESULT_W-1:0]  code;
    } result_type;

    typedef struct packed {
        logic pwm_module;
        logic software;
        logic external_conversion_trigger;
    } trigger_type;

endpackage : adc_seq_pkg

// [verilog/adc_powerup_sequential_sampling.sv]
// Purpose: power-up gating and sequential sampling timing of the converter
// Assumes: analog code arrives on i_analog_code each converter clock
// Notes:   dual-channel timing is handled elsewhere; mode bit 1 refuses triggers here
//
// Operation
// - all three power bits in one write accepted; full reference wait
// - sixteen software-selectable input channels, single or paired
// - each result is a 12-bit code from a four-stage pipeline
// - mode bit 0 selects sequential, 1 selects simultaneous sampling
// - conversions start from pwm module, software or external trigger
// - mode 0 converts selected channel on every sample/hold pulse
// - interrupt flag rises a few core cycles after result update
// - selected channel sampled on falling edge of sample/hold pulse
// - sample/hold pulse lasts one plus acquisition field converter clocks
// - sampling begins 2.5 converter periods after the trigger
// - first result appears 4 converter periods after sample/hold end
// - later results follow 2 plus acquisition field periods apart
`timescale 1ns/100ps
`default_nettype none

module adc_powerup_sequential_sampling #(
    parameter int REF_SETTLE  = adc_seq_pkg::REF_SETTLE_CYCLES,
    parameter int CORE_SETTLE = adc_seq_pkg::CORE_SETTLE_CYCLES
) (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_reset,
    input  wire logic [7:0]                        i_converter_control_reg3,
    input  wire logic [15:0]                       i_converter_control_reg1,
    input  wire logic                              i_dual_sample_select,
    input  wire logic                              i_continuous,
    input  wire logic [adc_seq_pkg::CHANNEL_W-1:0] i_channel,
    input  wire adc_seq_pkg::trigger_type          i_trigger,
    input  wire logic [adc_seq_pkg::RESULT_W-1:0]  i_analog_code,
    output logic                                   o_converter_clock,
    output logic                                   o_sample_hold,
    output logic                                   o_ready,
    output logic                                   o_busy,
    output adc_seq_pkg::result_type                o_result,
    output logic                                   o_irq_flag
);
    import adc_seq_pkg::*;

    localparam int SETTLE_W = 32;
    // wait count at which a run re-arms: one period after a hold ends
    localparam int REARM_AT = 2 * (FIRST_RESULT_CLKS - NEXT_RESULT_BASE) + 2;

    typedef enum {
        S_IDLE,
        S_DELAY,
        S_SAMPLE,
        S_WAIT
    } seq_state_type;

    ////////////////////////////////////////////////////////////////////////
    // converter clock enables: full-period tick and a half-period tick

    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic       conv_tick;
    logic       half_tick;

    always_comb
    begin
        next_div_cnt = (div_cnt == 3'(CONV_CLK_DIV - 1)) ? 3'h0
                                                         : div_cnt + 3'h1;
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
            div_cnt <= 3'h0;
        else
            div_cnt <= next_div_cnt;
    end

    // odd divide: half point sits at count 1, two cycles after the full tick
    assign conv_tick = (div_cnt == 3'(CONV_CLK_DIV - 1));
    assign half_tick = conv_tick || (div_cnt == 3'(CONV_CLK_DIV / 2 - 1));

    ////////////////////////////////////////////////////////////////////////
    // power-up settling

    logic                ref_on;
    logic                core_on;
    logic [SETTLE_W-1:0] ref_cnt;
    logic [SETTLE_W-1:0] core_cnt;
    logic [SETTLE_W-1:0] next_ref_cnt;
    logic [SETTLE_W-1:0] next_core_cnt;

    assign ref_on  = i_converter_control_reg3[CTRL3_BGREF1_BIT]
                   & i_converter_control_reg3[CTRL3_BGREF0_BIT];
    assign core_on = i_converter_control_reg3[CTRL3_CORE_PWR_BIT];

    always_comb
    begin
        // reference wait restarts whenever a reference bit drops
        next_ref_cnt = ref_cnt;
        if (!ref_on)
            next_ref_cnt = '0;
        else if (ref_cnt != SETTLE_W'(REF_SETTLE))
            next_ref_cnt = ref_cnt + 1'b1;
        // core wait only counts while both reference bits are set, alongside the reference wait
        next_core_cnt = core_cnt;
        if (!core_on || !ref_on)
            next_core_cnt = '0;
        else if (core_cnt != SETTLE_W'(CORE_SETTLE))
            next_core_cnt = core_cnt + 1'b1;
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ref_cnt  <= '0;
            core_cnt <= '0;
        end
        else
        begin
            ref_cnt  <= next_ref_cnt;
            core_cnt <= next_core_cnt;
        end
    end

    // all three bits in one write: both waits must pass
    assign o_ready = ref_on && core_on
                  && (ref_cnt == SETTLE_W'(REF_SETTLE))
                  && (core_cnt == SETTLE_W'(CORE_SETTLE));

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    seq_state_type             state;
    seq_state_type             next_state;
    logic [4:0]                cnt;
    logic [4:0]                next_cnt;
    logic [ACQ_W-1:0]          acq;
    logic                      trig_any;
    logic                      sh;
    logic                      next_sh;
    logic                      sample_now;
    logic [CHANNEL_W-1:0]      chan_held;
    logic [CHANNEL_W-1:0]      next_chan_held;

    assign acq = i_converter_control_reg1[CTRL1_ACQ_MSB:CTRL1_ACQ_LSB];
    // any of three sources, dropped unless powered
    assign trig_any = (i_trigger.pwm_module | i_trigger.software
                    | i_trigger.external_conversion_trigger) & o_ready;

    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt;
        next_sh        = sh;
        next_chan_held = chan_held;
        sample_now     = 1'b0;
        case (state)
            S_IDLE:
            begin
                if (trig_any && !i_dual_sample_select)
                begin
                    next_state = S_DELAY;
                    next_cnt   = 5'(TRIG_DELAY_HALVES);
                end
            end
            S_DELAY:
            begin
                // count five half ticks: 2.5 periods to within the phase of the trigger
                if (half_tick)
                begin
                    if (cnt == 5'h1)
                    begin
                        next_state = S_SAMPLE;
                        next_sh    = 1'b1;
                        next_cnt   = {acq, 1'b1};
                        next_chan_held = i_channel;
                    end
                    else
                        next_cnt = cnt - 5'h1;
                end
            end
            S_SAMPLE:
            begin
                // 2 * (1 + acq) half periods: exact whatever the phase
                if (half_tick)
                begin
                    if (cnt == 5'h0)
                    begin
                        // falling edge of sample/hold captures
                        next_sh    = 1'b0;
                        sample_now = 1'b1;
                        next_state = S_WAIT;
                        // stay busy until the result lands
                        next_cnt   = 5'(2 * FIRST_RESULT_CLKS - 1);
                    end
                    else
                        next_cnt = cnt - 5'h1;
                end
            end
            S_WAIT:
            begin
                if (half_tick)
                begin
                    // a continuous run re-arms one period on
                    if (cnt == 5'(REARM_AT) && i_continuous && o_ready
                        && !i_dual_sample_select)
                    begin
                        next_state = S_SAMPLE;
                        next_sh    = 1'b1;
                        next_cnt   = {acq, 1'b1};
                        next_chan_held = i_channel;
                    end
                    else if (cnt == 5'h0)
                        next_state = S_IDLE;
                    else
                        next_cnt = cnt - 5'h1;
                end
            end
            default:
                next_state = S_IDLE;
        endcase
        if (!o_ready)
        begin
            next_state = S_IDLE;
            next_sh    = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state     <= S_IDLE;
            cnt       <= 5'h0;
            sh        <= 1'b0;
            chan_held <= '0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            sh        <= next_sh;
            chan_held <= next_chan_held;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // four-stage pipeline, one stage per converter period, stepped on the
    // half tick kind that sampled: a result lands 4 periods after its hold
    // ends, and a run's results sit (1 + acq) + 1 periods apart

    logic [RESULT_W-1:0]    pipe_code [PIPE_STAGES];
    logic [CHANNEL_W-1:0]   pipe_chan [PIPE_STAGES];
    logic [PIPE_STAGES-1:0] pipe_vld;
    logic [PIPE_STAGES-1:0] next_pipe_vld;
    logic                   pipe_phase;
    logic                   next_pipe_phase;
    logic                   pipe_step;

    // phase only moves between runs, once the pipeline has drained
    assign pipe_step = sample_now
                     | (pipe_phase ? (half_tick & ~conv_tick) : conv_tick);

    always_comb
    begin
        next_pipe_vld   = pipe_vld;
        next_pipe_phase = pipe_phase;
        if (sample_now)
            next_pipe_phase = ~conv_tick;
        if (pipe_step)
            next_pipe_vld = {pipe_vld[PIPE_STAGES-2:0], sample_now};
        // samples in flight die with the power
        if (!o_ready)
            next_pipe_vld = '0;
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pipe_vld   <= '0;
            pipe_phase <= 1'b0;
        end
        else
        begin
            pipe_vld   <= next_pipe_vld;
            pipe_phase <= next_pipe_phase;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (pipe_step)
        begin
            for (int i = 1; i < PIPE_STAGES; i++)
            begin
                pipe_code[i] <= pipe_code[i-1];
                pipe_chan[i] <= pipe_chan[i-1];
            end
        end
        if (sample_now)
        begin
            pipe_code[0] <= i_analog_code;
            pipe_chan[0] <= chan_held;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result register and delayed flag

    result_type                    result;
    result_type                    next_result;
    logic [FLAG_DELAY_CYCLES-1:0]  flag_sr;
    logic [FLAG_DELAY_CYCLES-1:0]  next_flag_sr;
    logic                          update;

    assign update = pipe_step && pipe_vld[PIPE_STAGES-1];

    always_comb
    begin
        next_result       = result;
        next_result.valid = 1'b0;
        if (update)
        begin
            next_result.valid   = 1'b1;
            next_result.code    = pipe_code[PIPE_STAGES-1];
            next_result.channel = pipe_chan[PIPE_STAGES-1];
        end
        // flag trails the register update, never leads it
        next_flag_sr = {flag_sr[FLAG_DELAY_CYCLES-2:0], result.valid};
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            result  <= '0;
            flag_sr <= '0;
        end
        else
        begin
            result  <= next_result;
            flag_sr <= next_flag_sr;
        end
    end

    assign o_result          = result;
    assign o_irq_flag        = flag_sr[FLAG_DELAY_CYCLES-1];
    assign o_sample_hold     = sh;
    assign o_busy            = (state != S_IDLE);
    assign o_converter_clock = (div_cnt < 3'(CONV_CLK_DIV / 2 + 1));

endmodule : adc_powerup_sequential_sampling

`default_nettype wire

// [tb/adc_seq_checker.sv]
// Purpose: timing checks on the converter sequencer ports
// Assumes: control inputs held steady while a run is in flight
// Notes:   settle counts come in as parameters through the bind
`timescale 1ns/100ps
`default_nettype none
module adc_seq_checker
    import adc_seq_pkg::*;
#(
    parameter int REF_SETTLE  = 10,
    parameter int CORE_SETTLE = 5
) (
    input wire logic        i_core_clk,
    input wire logic        i_reset,
    input wire logic [7:0]  i_converter_control_reg3,
    input wire logic [15:0] i_converter_control_reg1,
    input wire logic        i_dual_sample_select,
    input wire logic        i_continuous,
    input wire logic [3:0]  i_channel,
    input wire trigger_type i_trigger,
    input wire logic [11:0] i_analog_code,
    input wire logic        o_converter_clock,
    input wire logic        o_sample_hold,
    input wire logic        o_ready,
    input wire logic        o_busy,
    input wire result_type  o_result,
    input wire logic        o_irq_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] sh_len;
    logic [7:0] gap;
    logic [3:0] ch_cap;
    int         ref_cnt;
    int         core_cnt;
    int         acq;
    assign acq = int'(i_converter_control_reg1[11:8]);
    wire  logic trig = i_trigger != '0;
    wire  logic accept = trig && o_ready && !o_busy && !i_dual_sample_select;
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sh_len   <= 8'h00;
            gap      <= 8'h00;
            ch_cap   <= 4'h0;
            ref_cnt  <= 0;
            core_cnt <= 0;
        end
        else
        begin
            sh_len   <= o_sample_hold ? sh_len + 8'h01 : 8'h00;
            gap      <= o_result.valid ? 8'h01 : !o_busy ? 8'h00 :
                        (gap != 8'h00) ? gap + 8'h01 : 8'h00;
            ch_cap   <= $rose(o_sample_hold) ? i_channel : ch_cap;
            ref_cnt  <= &i_converter_control_reg3[7:6] ? ref_cnt + 1 : 0;
            core_cnt <= &i_converter_control_reg3[7:5] ? core_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_hold_end;
        $fell(o_sample_hold) && o_ready;
    endsequence
    sequence s_lead;
        (!o_sample_hold)[*8] ##[4:6] $rose(o_sample_hold);
    endsequence
    a_trig_to_sample: assert property (accept |=> s_lead)
        else $error("sample/hold start off after trigger");
    a_hold_width: assert property (s_hold_end
        |-> sh_len == 5 * (1 + acq))
        else $error("sample/hold width wrong");
    a_first_result: assert property (s_hold_end
        |-> ##20 o_result.valid)
        else $error("result late or early after hold end");
    a_result_spacing: assert property (o_result.valid
        && gap != 8'h00 |-> gap == 5 * (2 + acq))
        else $error("result spacing wrong");
    a_flag_follows: assert property (o_result.valid
        |-> ##3 o_irq_flag)
        else $error("flag missing after result");
    a_flag_cause: assert property (o_irq_flag
        |-> $past(o_result.valid, 3))
        else $error("flag without result");
    a_refused_idle: assert property ((trig && !o_busy
        && (!o_ready || i_dual_sample_select)) |=> !o_busy)
        else $error("trigger not refused");
    a_power_abort: assert property ($fell(o_ready)
        |-> ##[1:2] !o_busy)
        else $error("no abort on power loss");
    a_result_chan: assert property (o_result.valid
        |-> o_result.channel == ch_cap)
        else $error("result channel wrong");
    a_ready_settled: assert property ($rose(o_ready)
        |-> ref_cnt >= REF_SETTLE - 1 && core_cnt >= CORE_SETTLE - 1)
        else $error("ready before settling");
    a_conv_clock: assert property ($rose(o_converter_clock) |=>
        (!$rose(o_converter_clock))[*4] ##1 $rose(o_converter_clock))
        else $error("converter clock period wrong");
endmodule : adc_seq_checker
bind adc_powerup_sequential_sampling adc_seq_checker #(
    .REF_SETTLE(REF_SETTLE), .CORE_SETTLE(CORE_SETTLE)) adc_seq_checker_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_converter_control_reg3(i_converter_control_reg3),
    .i_converter_control_reg1(i_converter_control_reg1),
    .i_dual_sample_select(i_dual_sample_select),
    .i_continuous(i_continuous), .i_channel(i_channel),
    .i_trigger(i_trigger), .i_analog_code(i_analog_code),
    .o_converter_clock(o_converter_clock), .o_sample_hold(o_sample_hold),
    .o_ready(o_ready), .o_busy(o_busy), .o_result(o_result),
    .o_irq_flag(o_irq_flag));
`default_nettype wire

// [tb/analog_source_model.sv]
// Purpose: analog inputs seen through a track-and-hold
// Assumes: code wanders every cycle while the hold pulse is low
// Notes:   a late capture sees a different code
`timescale 1ns/100ps
`default_nettype none
module analog_source_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_sample_hold,
    output logic [11:0]      o_code
);
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
            o_code <= 12'h5a3;
        else if (!i_sample_hold)
            o_code <= {o_code[10:0], o_code[11] ^ o_code[8]};
    end
endmodule : analog_source_model
`default_nettype wire

// [tb/adc_powerup_sequential_sampling_bench.sv]
// Purpose: self-checking bench for the converter sequencer
// Assumes: software role played here; analog side by the model
// Notes:   timing checked by the bound checker, data here
`timescale 1ns/100ps
`default_nettype none
module adc_powerup_sequential_sampling_bench;
    import adc_seq_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg3 = 8'h00;
    logic [15:0] reg1 = 16'h0000;
    logic        dual = 1'b0;
    logic        cont = 1'b0;
    logic [3:0]  ch = 4'h0;
    trigger_type trig = '0;
    logic [11:0] code;
    logic        cclk, sh, rdy, busy, flag;
    result_type  res;
    int          bad_count = 0;
    int          n_checks = 0;
    logic [3:0]  ch_q[$];
    logic [11:0] code_q[$];
    logic        sh_d = 1'b0;
    logic [FLAG_DELAY_CYCLES-1:0] vd = '0;
    int          k, j;
    adc_powerup_sequential_sampling #(.REF_SETTLE(10), .CORE_SETTLE(5))
    adc_powerup_sequential_sampling_i (
        .i_core_clk(clk), .i_reset(rst), .i_converter_control_reg3(reg3),
        .i_converter_control_reg1(reg1), .i_dual_sample_select(dual),
        .i_continuous(cont), .i_channel(ch), .i_trigger(trig),
        .i_analog_code(code), .o_converter_clock(cclk),
        .o_sample_hold(sh), .o_ready(rdy), .o_busy(busy),
        .o_result(res), .o_irq_flag(flag));
    analog_source_model analog_source_model_i (
        .i_core_clk(clk), .i_reset(rst), .i_sample_hold(sh), .o_code(code));
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task fire(input trigger_type t);
        trig = t;
        tick(1);
        trig = '0;
    endtask : fire
    task wait_ready;
        for (int i = 0; i < 100 && rdy !== 1'b1; i++) tick(1);
        check("ready", 16'(rdy), 16'h0001);
    endtask : wait_ready
    // one shot with a refused retrigger while the run is busy
    task run_one(input logic [3:0] acq, input trigger_type t);
        ch = 4'($urandom);
        reg1[11:8] = acq;
        ch_q.push_back(ch);
        fire(t);
        tick(3);
        fire(t);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) tick(1);
        tick(5);
        check("pending", 16'(ch_q.size()), 16'h0000);
    endtask : run_one
    ////////////////////////////////////////////////////////////////////////
    // results pair with the oldest note; code is the held input at hold end
    always @(posedge clk)
    begin
        if (sh_d === 1'b1 && sh === 1'b0) code_q.push_back(code);
        sh_d = sh;
        if (res.valid === 1'b1)
        begin
            if (ch_q.size() == 0 || code_q.size() == 0)
                check("extra result", 16'h0001, 16'h0000);
            else
            begin
                check("channel", 16'(res.channel),
                      16'(ch_q.pop_front()));
                check("code", 16'(res.code),
                      16'(code_q.pop_front()));
            end
        end
        // flag trails each result by the fixed flag delay
        if (rst === 1'b0)
            check("flag", 16'(flag), 16'(vd[FLAG_DELAY_CYCLES-1]));
        vd = {vd[FLAG_DELAY_CYCLES-2:0], res.valid};
    end
    initial forever #4 clk = ~clk;
    initial
    begin
        #200000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h2c59));
        tick(6);
        rst = 1'b0;
        fire(trigger_type'(3'b010));
        tick(20);
        check("busy unpowered", 16'(busy), 16'h0000);
        reg3 = 8'he0;
        tick(2);
        fire(trigger_type'(3'b001));
        wait_ready();
        check("busy settling", 16'(busy), 16'h0000);
        ch = 4'($urandom_range(7, 0));
        dual = 1'b1;
        fire(trigger_type'(3'b100));
        tick(20);
        check("busy dual", 16'(busy), 16'h0000);
        dual = 1'b0;
        for (k = 0; k < 3; k++)
            for (j = 0; j < 2; j++)
                run_one(j == 0 ? 4'h0 : 4'($urandom_range(15, 1)),
                        trigger_type'(3'b001 << k));
        // widest hold keeps the next sample open across the abort
        cont = 1'b1;
        reg1[11:8] = 4'hf;
        ch = 4'($urandom);
        repeat (3) ch_q.push_back(ch);
        fire(trigger_type'(3'b100));
        for (int i = 0; i < 600 && ch_q.size() != 0; i++) tick(1);
        check("run results", 16'(ch_q.size()), 16'h0000);
        tick(4);
        reg3 = 8'hc0;
        tick(3);
        check("busy abort", 16'(busy), 16'h0000);
        cont = 1'b0;
        tick(100);
        code_q.delete();
        reg3 = 8'he0;
        wait_ready();
        run_one(4'h3, trigger_type'(3'b001));
        complete_run();
    end
endmodule : adc_powerup_sequential_sampling_bench
`default_nettype wire
